// *** common/ee_pkg.sv ***
// constants and types shared by the two-wire eeprom slave
// assumes a 10 mhz system clock and a master-driven serial clock
package ee_pkg;
    localparam int ADDR_W = 8; // one word address byte
    localparam int DATA_W = 8; // byte-wide storage
    localparam int MEM_DEPTH = 256; // bytes in the array
    localparam int PAGE_DEPTH = 8; // bytes per page
    localparam int PAGE_IDX_W = 3; // byte index inside a page
    localparam int PAGE_NUM_W = 5; // 32 pages
    localparam int CNT_W = 4; // bit counter width
    localparam logic [CNT_W-1:0] ACK_SLOT = 4'h8; // ninth clock of a word
    localparam logic [CNT_W-1:0] LAST_BIT = 4'h7; // eighth clock of a word
    localparam logic [3:0] DEV_TYPE = 4'ha; // device type code, arbitrary value
    localparam int RW_BIT = 0; // read/write flag in the select byte
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff; // array content after reset
    localparam int SYS_CLK_PERIOD_NS = 100; // 10 mhz system clock
    localparam int T_WR_MAX_NS = 5000000; // self-timed write, 5 ms at most
    localparam int T_WR_CYC = T_WR_MAX_NS / SYS_CLK_PERIOD_NS; // longest time rounds down
    localparam int TMR_W = $clog2(T_WR_CYC + 1); // timer counter width

    // link side transaction phase
    typedef enum logic [2:0] {
        LK_IDLE = 3'b000,
        LK_DEV = 3'b001,
        LK_WADDR = 3'b010,
        LK_WDATA = 3'b011,
        LK_RDATA = 3'b100
    } ee_link_st_t;

    // programming engine phase
    typedef enum logic [0:0] {
        PG_IDLE = 1'b0,
        PG_PROG = 1'b1
    } ee_prog_st_t;
endpackage

// *** common/ee_tmr_if.sv ***
// handshake between the programming engine and its write timer
// assumes both ends run on the system clock
`timescale 1ns/1ns
interface ee_tmr_if;
    logic start; // one-cycle pulse, load and run the timer
    logic done; // one-cycle pulse, write time has elapsed

    modport ctrl (output start, input done);
    modport tmr (input start, output done);
endinterface

// *** logic/ee_prog_timer.sv ***
// self-timed write cycle counter
// assumes start is a single-cycle pulse on sys_clk_i
`timescale 1ns/1ns
module ee_prog_timer
    import ee_pkg::*;
#(
    parameter int CYC = T_WR_CYC
) (
    input wire logic sys_clk_i, // system clock
    input wire logic srst_i, // synchronous reset, active high
    ee_tmr_if.tmr tmr // start in, done out
);
    typedef struct packed {
        logic run; // counting
        logic [TMR_W-1:0] cnt; // cycles left
        logic done; // elapsed pulse
    } ee_tmr_state_t;

    ee_tmr_state_t st_reg; // registered state
    ee_tmr_state_t st_next; // next state

    // countdown, a fresh start restarts the count
    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (srst_i) begin
            st_next = '0;
        end else if (tmr.start) begin
            st_next.run = 1'b1;
            // busy then lasts cyc-3 cycles; with up to 3 cycles of stop
            // synchronisation the write stays inside the cyc budget
            st_next.cnt = TMR_W'(CYC - 5);
        end else if (st_reg.run) begin
            if (st_reg.cnt == '0) begin // time is up
                st_next.run = 1'b0;
                st_next.done = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt - 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk_i) begin
        st_reg <= st_next;
    end

    assign tmr.done = st_reg.done;
endmodule

// *** logic/ee_slave.sv ***
// two-wire serial eeprom slave, 256 bytes in 32 pages of 8
// assumes scl_i is the master's serial clock used as a clock port,
// sda is open drain with an external pull-up resolved outside
// Operation
// [RL1] 256 bytes, each individually read and written
// [RL2] sample on scl rise, drive on fall
// [RL3] sda only pulled low or released
// [RL4] write protect low: reads and writes normal
// [RL5] write protect high: array never altered; wp is only sampled at the stop, so a commit already started still completes
// [RL6] 32 pages of 8, one address byte
// [RL7] page writes up to eight, partial allowed
// [RL8] self-timed commit after stop, 5 ms max
// [RL9] master changes sda only while scl low
// [RL10] sda fall with scl high starts transaction
// [RL11] sda rise with scl high ends transaction
// [RL12] byte words, receiver acks on ninth clock
// [RL13] page write wraps on low three bits
// [RL14] no acknowledge while programming is pending
`timescale 1ns/1ns
module ee_slave
    import ee_pkg::*;
#(
    parameter int T_WR_CYC_P = T_WR_CYC // write time in system cycles
) (
    input wire logic sys_clk_i, // system clock, 10 mhz
    input wire logic srst_i, // synchronous reset, active high
    input wire logic scl_i, // serial clock from the master
    input wire logic sda_i, // serial data line level
    output logic sda_o, // serial data drive value, always low
    output logic sda_oe_n_o, // low while pulling sda low
    input wire logic wp_i, // write protect, high protects
    output logic standby_o, // idle after stop, nothing pending
    output logic busy_o // self-timed write running
);
    // link side state, clocked on the rising serial clock
    typedef struct packed {
        logic [1:0] rst_sy; // reset synchroniser
        logic [1:0] done_sy; // commit-done toggle synchroniser
        logic [1:0] busy_sy; // programming busy synchroniser
        logic done_seen; // last done toggle acted on
        ee_link_st_t st; // transaction phase
        logic [CNT_W-1:0] cnt; // bit position in word
        logic [DATA_W-1:0] sh; // receive shifter
        logic sda_hi; // line level at last rise
        logic ack; // acknowledge on the coming ninth clock
        logic [ADDR_W-1:0] ptr; // word address pointer
        logic [PAGE_NUM_W-1:0] page; // page being written
        logic [DATA_W-1:0] tx; // byte being read out
        logic [PAGE_DEPTH-1:0] mask; // bytes received for commit
        logic [PAGE_DEPTH-1:0][DATA_W-1:0] pbuf; // page buffer
    } ee_link_state_t;

    // link side state, clocked on the falling serial clock
    typedef struct packed {
        logic start; // start seen during last high phase
        logic oe_n; // sda pull-down, low drives
    } ee_drv_state_t;

    // system side state
    typedef struct packed {
        logic [1:0] stop_sy; // stop level synchroniser
        logic stop_prev; // for stop edge detection
        logic [1:0] wp_sy; // write protect synchroniser
        ee_prog_st_t st; // programming phase
        logic done_tgl; // flips on each finished commit
        logic busy; // programming in progress
        logic standby; // low power idle
        logic [MEM_DEPTH-1:0][DATA_W-1:0] arr; // nonvolatile array
    } ee_sys_state_t;

    ee_link_state_t lnk_reg; // link registers
    ee_link_state_t lnk_next; // link next state
    ee_drv_state_t drv_reg; // drive registers
    ee_drv_state_t drv_next; // drive next state
    ee_sys_state_t sys_reg; // system registers
    ee_sys_state_t sys_next; // system next state
    logic stop_lvl_reg; // last sda rise happened with scl high
    ee_tmr_if tmr_if (); // timer handshake

    // stop detector: sda rising while scl is high; a rise with scl low
    // (a normal data change) clears it, so the level is stable in idle
    always_ff @(posedge sda_i) begin
        stop_lvl_reg <= scl_i; // RL11
    end

    // ---------------- link, rising serial clock ----------------
    always_comb begin
        logic [DATA_W-1:0] byte_in; // word including this bit
        logic busy_l; // refuse new transactions
        byte_in = {lnk_reg.sh[DATA_W-2:0], sda_i};
        busy_l = lnk_reg.busy_sy[1] | (lnk_reg.mask != '0); // RL14
        lnk_next = lnk_reg;
        lnk_next.rst_sy = {lnk_reg.rst_sy[0], srst_i};
        lnk_next.done_sy = {lnk_reg.done_sy[0], sys_reg.done_tgl};
        lnk_next.busy_sy = {lnk_reg.busy_sy[0], sys_reg.busy};
        lnk_next.sda_hi = sda_i; // RL2
        // commit finished: the buffer may be refilled
        if (lnk_reg.done_sy[1] != lnk_reg.done_seen) begin
            lnk_next.done_seen = lnk_reg.done_sy[1];
            lnk_next.mask = '0;
        end
        if (lnk_reg.rst_sy[1]) begin
            lnk_next.done_seen = 1'b0;
            lnk_next.st = LK_IDLE;
            lnk_next.cnt = '0;
            lnk_next.ack = 1'b0;
            lnk_next.ptr = '0;
            lnk_next.mask = '0;
        end else if (drv_reg.start) begin
            // first select bit arrives on this rise
            lnk_next.st = LK_DEV; // RL10
            lnk_next.cnt = 4'h1;
            lnk_next.sh = {7'h00, sda_i};
            lnk_next.ack = 1'b0;
        end else if (lnk_reg.st == LK_IDLE) begin
            lnk_next.cnt = '0; // wait for a start
        end else if (lnk_reg.cnt != ACK_SLOT) begin
            // data bit of a word
            lnk_next.sh = byte_in; // RL2
            lnk_next.cnt = lnk_reg.cnt + 1'b1;
            if (lnk_reg.cnt == LAST_BIT) begin
                case (lnk_reg.st)
                    LK_DEV: lnk_next.ack = (byte_in[7:4] == DEV_TYPE) & ~busy_l; // RL14
                    LK_WADDR: lnk_next.ack = 1'b1; // RL12
                    LK_WDATA: lnk_next.ack = 1'b1; // RL12
                    default: lnk_next.ack = 1'b0; // read bytes are acked by the master
                endcase
            end
        end else begin
            // ninth clock: act on the finished word
            lnk_next.cnt = '0;
            lnk_next.ack = 1'b0;
            case (lnk_reg.st)
                LK_DEV: begin
                    if (!lnk_reg.ack) begin
                        lnk_next.st = LK_IDLE; // not ours or busy
                    end else if (lnk_reg.sh[RW_BIT]) begin
                        lnk_next.st = LK_RDATA; // read from current address
                        lnk_next.tx = sys_reg.arr[lnk_reg.ptr]; // RL1
                        lnk_next.ptr = lnk_reg.ptr + 1'b1;
                    end else begin
                        lnk_next.st = LK_WADDR;
                    end
                end
                LK_WADDR: begin
                    // single address byte selects page and byte
                    lnk_next.ptr = lnk_reg.sh; // RL6
                    lnk_next.page = lnk_reg.sh[ADDR_W-1:PAGE_IDX_W]; // RL6
                    lnk_next.st = LK_WDATA;
                end
                LK_WDATA: begin
                    lnk_next.pbuf[lnk_reg.ptr[PAGE_IDX_W-1:0]] = lnk_reg.sh; // RL7
                    lnk_next.mask[lnk_reg.ptr[PAGE_IDX_W-1:0]] = 1'b1; // RL7
                    // only the low bits advance, later bytes overwrite the page
                    lnk_next.ptr[PAGE_IDX_W-1:0] = lnk_reg.ptr[PAGE_IDX_W-1:0] + 1'b1; // RL13
                end
                LK_RDATA: begin
                    if (!sda_i) begin // master acked, keep reading
                        lnk_next.tx = sys_reg.arr[lnk_reg.ptr]; // RL1
                        lnk_next.ptr = lnk_reg.ptr + 1'b1;
                    end else begin
                        lnk_next.st = LK_IDLE; // RL12
                    end
                end
                default: lnk_next.st = LK_IDLE;
            endcase
        end
    end

    // link registers
    always_ff @(posedge scl_i) begin
        lnk_reg <= lnk_next;
    end

    // ---------------- link, falling serial clock ----------------
    always_comb begin
        logic [PAGE_IDX_W-1:0] bit_sel; // read bit, msb first
        bit_sel = PAGE_IDX_W'(LAST_BIT[PAGE_IDX_W-1:0] - lnk_reg.cnt[PAGE_IDX_W-1:0]);
        drv_next = drv_reg;
        // sda was high at the rise and is low now: fell during high
        drv_next.start = lnk_reg.sda_hi & ~sda_i; // RL10
        drv_next.oe_n = 1'b1; // released by default
        if (lnk_reg.rst_sy[1]) begin
            drv_next.start = 1'b0;
        end else if (drv_next.start) begin
            drv_next.oe_n = 1'b1; // a new start cancels any drive
        end else if (lnk_reg.cnt == ACK_SLOT) begin
            drv_next.oe_n = ~lnk_reg.ack; // RL12
        end else if (lnk_reg.st == LK_RDATA) begin
            drv_next.oe_n = lnk_reg.tx[bit_sel]; // RL2
        end
    end

    // drive registers change only on the falling edge
    always_ff @(negedge scl_i) begin
        drv_reg <= drv_next; // RL2
    end

    // ---------------- system side, programming engine ----------------
    always_comb begin
        logic stop_rise; // stop just seen
        logic [ADDR_W-1:0] waddr; // array address of a page byte
        stop_rise = sys_reg.stop_sy[1] & ~sys_reg.stop_prev;
        waddr = '0;
        sys_next = sys_reg;
        sys_next.stop_sy = {sys_reg.stop_sy[0], stop_lvl_reg};
        sys_next.stop_prev = sys_reg.stop_sy[1];
        sys_next.wp_sy = {sys_reg.wp_sy[0], wp_i};
        tmr_if.start = 1'b0;
        if (srst_i) begin
            sys_next.stop_prev = 1'b0;
            sys_next.st = PG_IDLE;
            sys_next.done_tgl = 1'b0;
            sys_next.busy = 1'b0;
            sys_next.arr = {MEM_DEPTH{ERASED_BYTE}};
        end else begin
            case (sys_reg.st)
                PG_IDLE: begin
                    // link is quiet after a stop, its buffer is stable
                    if (stop_rise && (lnk_reg.mask != '0)) begin
                        if (!sys_reg.wp_sy[1]) begin // RL4
                            sys_next.st = PG_PROG;
                            sys_next.busy = 1'b1; // RL14
                            tmr_if.start = 1'b1; // RL8
                        end else begin
                            // protected: drop the bytes, release the link
                            sys_next.done_tgl = ~sys_reg.done_tgl; // RL5
                        end
                    end
                end
                PG_PROG: begin
                    if (tmr_if.done) begin // RL8
                        for (int i = 0; i < PAGE_DEPTH; i++) begin
                            waddr = {lnk_reg.page, PAGE_IDX_W'(i)};
                            if (lnk_reg.mask[i]) begin
                                sys_next.arr[waddr] = lnk_reg.pbuf[i]; // RL7
                            end
                        end
                        sys_next.done_tgl = ~sys_reg.done_tgl;
                        sys_next.busy = 1'b0;
                        sys_next.st = PG_IDLE;
                    end
                end
                default: sys_next.st = PG_IDLE;
            endcase
        end
        // standby once stopped and no internal operation remains
        sys_next.standby = (sys_next.st == PG_IDLE) & sys_reg.stop_sy[1] & ~srst_i; // RL11
    end

    // system registers
    always_ff @(posedge sys_clk_i) begin
        sys_reg <= sys_next;
    end

    // write cycle timer
    ee_prog_timer #(
        .CYC(T_WR_CYC_P)
    ) u_timer (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .tmr(tmr_if)
    );

    // open drain: the drive value is always low, only the enable moves
    assign sda_o = 1'b0; // RL3
    assign sda_oe_n_o = drv_reg.oe_n;
    assign standby_o = sys_reg.standby;
    assign busy_o = sys_reg.busy;
endmodule

// *** tb/ee_slave_chk.sv ***
// concurrent checks on the ports of the eeprom slave
// assumes binding onto ee_slave; scl only toggles inside frames
`timescale 1ns/1ns
module ee_slave_chk
    import ee_pkg::*;
#(
    parameter int T_WR_CYC_P = T_WR_CYC // write time in system cycles
) (
    input wire logic sys_clk_i, // system clock
    input wire logic srst_i, // synchronous reset, active high
    input wire logic scl_i, // serial clock
    input wire logic sda_i, // resolved data line
    input wire logic sda_o, // drive value
    input wire logic sda_oe_n_o, // low while pulling sda
    input wire logic wp_i, // write protect
    input wire logic standby_o, // idle after stop
    input wire logic busy_o // self-timed write running
);
    int busy_cnt; // busy cycles so far
    logic oe_n_at_rise; // drive level at the last scl rise
    // count busy cycles, a stuck busy overruns the bound
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_o ? busy_cnt + 1 : 0;
        end
    end
    // drive level held while scl is high
    always_ff @(posedge scl_i) begin
        oe_n_at_rise <= sda_oe_n_o;
    end
    property p_drive_low;
        @(posedge sys_clk_i) disable iff (srst_i) sda_o == 1'b0;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("sda drive value not low");
    property p_bit_hold;
        @(negedge scl_i) disable iff (srst_i) sda_oe_n_o == oe_n_at_rise;
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("sda drive moved while scl high");
    property p_busy_nak;
        @(posedge sys_clk_i) disable iff (srst_i) busy_o |-> sda_oe_n_o;
    endproperty
    a_busy_nak: assert property (p_busy_nak) else $error("sda pulled while busy");
    property p_busy_min;
        @(posedge sys_clk_i) disable iff (srst_i) $fell(busy_o) |-> busy_cnt >= T_WR_CYC_P - 3;
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("write time too short");
    property p_busy_max;
        @(posedge sys_clk_i) disable iff (srst_i) busy_o |-> busy_cnt <= T_WR_CYC_P - 4;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("write time too long");
    property p_busy_run;
        @(posedge sys_clk_i) disable iff (srst_i) $rose(busy_o) |-> busy_o [*8];
    endproperty
    a_busy_run: assert property (p_busy_run) else $error("busy dropped early");
    property p_standby_excl;
        @(posedge sys_clk_i) disable iff (srst_i) !(standby_o && busy_o);
    endproperty
    a_standby_excl: assert property (p_standby_excl) else $error("standby while busy");
    property p_standby_after;
        @(posedge sys_clk_i) disable iff (srst_i) $fell(busy_o) |-> ##[0:3] standby_o;
    endproperty
    a_standby_after: assert property (p_standby_after) else $error("no standby after write");
    c_busy: cover property (@(posedge sys_clk_i) disable iff (srst_i) $rose(busy_o));
    c_ack: cover property (@(negedge scl_i) disable iff (srst_i) !sda_oe_n_o);
    c_standby: cover property (@(posedge sys_clk_i) disable iff (srst_i) $rose(standby_o));
endmodule

bind ee_slave ee_slave_chk #(.T_WR_CYC_P(T_WR_CYC_P)) chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wp_i(wp_i),
    .standby_o(standby_o), .busy_o(busy_o));

// *** tb/ee_master_bfm.sv ***
// behavioural two-wire bus master facing the eeprom slave
// assumes sda_i is the resolved wire with a pull-up; scl stands high between frames
`timescale 1ns/1ns
module ee_master_bfm (
    input wire logic sda_i, // resolved data line
    output logic scl_o, // serial clock, 32 ns period
    output logic sda_oe_n_o // low while pulling sda low
);
    logic got; // level sampled at the last rise
    // bus idle at time zero
    initial begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end
    // one clock, data set 8 ns after the fall so start sampling stays clean
    task automatic clk_bit(input logic b);
        sda_oe_n_o = b; // only pulls low or releases
        #8 scl_o = 1'b1;
        got = sda_i;
        #16 scl_o = 1'b0;
        #8;
    endtask
    // start or repeated start
    task automatic start();
        sda_oe_n_o = 1'b1;
        #8 scl_o = 1'b1;
        #8 sda_oe_n_o = 1'b0; // fall with clock high
        #8 scl_o = 1'b0;
        #8;
    endtask
    // clock then stands high
    task automatic stop();
        sda_oe_n_o = 1'b0;
        #8 scl_o = 1'b1;
        #8 sda_oe_n_o = 1'b1; // rise with clock high
        #16;
    endtask
    // byte out msb first, ninth clock returns the slave's answer
    task automatic put(input logic [7:0] v, output logic ack_n);
        for (int i = 7; i >= 0; i--) clk_bit(v[i]);
        clk_bit(1'b1);
        ack_n = got;
    endtask
    // byte in, then ack low to go on or high to end
    task automatic get(input logic last, output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1);
            v[i] = got;
        end
        clk_bit(last);
    endtask
endmodule

// *** tb/test_two_wire_eeprom_2kbit_slave.sv ***
// self-checking bench for the eeprom slave with a master model
// assumes write time shortened to 40 system cycles
`timescale 1ns/1ns
module test_two_wire_eeprom_2kbit_slave;
    import ee_pkg::*;
    localparam int TW = 40; // shortened write time
    logic sys_clk = 1'b0; // 10 mhz
    logic srst = 1'b1; // reset held at start
    logic wp = 1'b0; // write protect
    logic scl, m_oe_n, s_oe_n, s_drv, standby, busy; // link and status
    logic [7:0] mem [256]; // expected array
    int n_errors = 0; // mismatches
    int num_checks = 0; // comparisons
    int cyc = 0; // timeout counter
    wire sda = (s_oe_n ? 1'b1 : s_drv) & m_oe_n; // pull-up, wired low
    ee_slave #(.T_WR_CYC_P(TW)) uut (.sys_clk_i(sys_clk), .srst_i(srst), .scl_i(scl), .sda_i(sda),
        .sda_o(s_drv), .sda_oe_n_o(s_oe_n), .wp_i(wp), .standby_o(standby), .busy_o(busy));
    ee_master_bfm mst (.sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n));
    initial forever #50 sys_clk = ~sys_clk;
    // hang guard, far above the expected run
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // idle clocks let the link side see reset and write completion
    task automatic frame(input logic go);
        for (int i = 0; i < 4; i++) mst.clk_bit(1'b1);
        if (go) mst.start();
    endtask
    // select, address, n bytes counting up from v0, stop
    task automatic wr(input logic [7:0] a, input int n, input logic [7:0] v0);
        logic ack_n;
        logic [7:0] v;
        frame(1'b1);
        mst.put({DEV_TYPE, 3'h0, 1'b0}, ack_n);
        check("write select ack", 8'h00, {7'h0, ack_n});
        mst.put(a, ack_n);
        check("address ack", 8'h00, {7'h0, ack_n});
        for (int i = 0; i < n; i++) begin
            v = v0 + 8'(i);
            mst.put(v, ack_n);
            check("data ack", 8'h00, {7'h0, ack_n});
            if (wp === 1'b0) mem[{a[7:3], a[2:0] + 3'(i)}] = v; // index folds in page
        end
        mst.stop();
    endtask
    // with exp_busy set, busy must rise soon after stop; busy must then clear within TW+10 further cycles
    task automatic settle(input logic exp_busy);
        logic seen;
        seen = 1'b0;
        repeat (6) begin
            @(posedge sys_clk);
            #1 seen = seen | busy;
        end
        if (exp_busy) check("busy after stop", 8'h01, {7'h0, seen});
        for (int k = 0; k < TW + 10 && busy !== 1'b0; k++) @(posedge sys_clk);
        #1 check("busy cleared", 8'h00, {7'h0, busy});
    endtask
    // random read of n bytes through a repeated start
    task automatic rd(input logic [7:0] a, input int n);
        logic ack_n;
        logic [7:0] v;
        frame(1'b1);
        mst.put({DEV_TYPE, 3'h0, 1'b0}, ack_n);
        mst.put(a, ack_n);
        mst.start();
        mst.put({DEV_TYPE, 3'h0, 1'b1}, ack_n);
        check("read select ack", 8'h00, {7'h0, ack_n});
        for (int i = 0; i < n; i++) begin
            mst.get(i == n - 1, v);
            check("read byte", mem[a + 8'(i)], v);
        end
        mst.stop();
        repeat (6) @(posedge sys_clk);
        #1 check("standby after read", 8'h01, {7'h0, standby});
    endtask
    // a select that must be left unanswered
    task automatic probe(input logic [3:0] kind);
        logic ack_n;
        repeat (4) @(posedge sys_clk);
        frame(1'b1);
        mst.put({kind, 3'h0, 1'b0}, ack_n);
        check("refused select", 8'h01, {7'h0, ack_n});
        mst.stop();
    endtask
    initial begin
        foreach (mem[i]) mem[i] = ERASED_BYTE;
        frame(1'b0); // scl edges while reset is held
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        rd(8'hfe, 3); // pointer wraps to zero
        wr(8'h35, 1, 8'h5a);
        settle(1'b1);
        rd(8'h35, 1);
        wr(8'h7d, 10, 8'h20); // ten bytes fold inside one page
        settle(1'b1);
        rd(8'h77, 10); // neighbouring pages untouched
        wr(8'h12, 3, 8'hc0); // partial page
        settle(1'b1);
        rd(8'h10, 8);
        @(posedge sys_clk);
        wp <= 1'b1;
        wr(8'h35, 2, 8'h99); // acked, then discarded
        settle(1'b0);
        rd(8'h34, 3);
        @(posedge sys_clk);
        wp <= 1'b0;
        wr(8'h40, 1, 8'h77);
        probe(DEV_TYPE); // select during programming
        settle(1'b1);
        rd(8'h40, 1);
        probe(~DEV_TYPE); // foreign type code
        final_report();
    end
endmodule
